// ---- rtl/bit_flag_transfer_exec_unit.sv ----
// Function
// - Program store writes r1:r0 at extension:Z, then Z plus 2, flags kept.
// - I/O in copies addressed I/O location to destination in one cycle.
// - Push writes register to stack in one cycle, no flags changed.
// - Pop loads destination from stack in two cycles, no flags changed.
// - Rotate left through carry, updates Z C N V H.
// - Rotate right through carry, updates Z C N V, not H.
// - Set I/O bit forces selected bit to one, others kept.
// - Clear I/O bit forces selected bit to zero, others kept.
// - Bit store copies register bit into transfer flag only.
// - Bit load copies transfer flag into register bit, no flags.
// - Overflow flag can be set or cleared alone.
// - Half-carry flag can be set alone.
// - Half-carry flag can be cleared alone.
// - Signed test flag can be set or cleared alone.
// - Break takes one cycle, changes no flag.
// - Sleep issues in one cycle, flags kept, sleep request raised.
// - Watchdog restart issues in one cycle, flags kept, restarts watchdog.
// - Memory cycle counts hold for internal memory; external may wait longer.
// - One extra cycle is added for internal SRAM data accesses.
`timescale 1ns/1ps
`default_nettype none

module bit_flag_transfer_exec_unit (
    input wire logic clk, // Core clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic op_valid, // Operation offered this cycle.
    input wire exec_unit_pkg::op_type op_code, // Operation to execute.
    input wire logic [7:0] operand_value, // Source or destination register value.
    input wire logic [2:0] bit_index, // Bit select or status flag index.
    input wire logic [5:0] io_address, // I/O location operand.
    input wire logic [7:0] reg_r0, // Register r0.
    input wire logic [7:0] reg_r1, // Register r1.
    input wire logic [15:0] z_pointer, // Z pointer value.
    input wire logic [7:0] program_address_extension, // Upper program address bits.
    input wire logic sram_access, // Stack lies in internal SRAM.
    input wire logic mem_wait, // External memory stretches the access.
    input wire logic [7:0] io_read_data, // Data from the addressed I/O location.
    input wire logic [7:0] stack_read_data, // Data read from the stack.
    output logic busy, // Operation in progress; new ones refused.
    output logic done, // One-cycle pulse when an operation retires.
    output logic result_write, // Pulse: result_value goes to the destination register.
    output logic [7:0] result_value, // Value for the destination register.
    output logic [7:0] status_flags_register, // Current status flags.
    output logic z_write, // Pulse: z_value replaces the Z pointer.
    output logic [15:0] z_value, // Updated Z pointer.
    output logic pm_write, // Pulse: program word write.
    output logic [23:0] pm_address, // Program word address.
    output logic [15:0] pm_data, // Program word data, r1:r0.
    output logic io_read, // Pulse: read the addressed I/O location.
    output logic io_write, // Pulse: write the addressed I/O location.
    output logic [5:0] io_write_address, // I/O location written.
    output logic [7:0] io_write_data, // I/O write data.
    output logic stack_write, // Pulse: write stack location.
    output logic stack_read, // Pulse: read stack location.
    output logic [15:0] stack_pointer, // Current stack pointer.
    output logic [7:0] stack_write_data, // Data pushed.
    output logic break_event, // Pulse on break.
    output logic sleep_request, // Pulse on sleep.
    output logic watchdog_restart // Pulse restarting the watchdog.
);
    import exec_unit_pkg::*;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_wait = 2'b10
    } state_type;

    state_type state_q, state_d;
    op_type op_q, op_d;
    logic [1:0] count_q, count_d;
    logic [5:0] addr_q, addr_d;
    logic [7:0] flags_q, flags_d;
    logic [15:0] sp_q, sp_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic rw_q, rw_d;
    logic [7:0] res_q, res_d;
    logic zw_q, zw_d;
    logic [15:0] zv_q, zv_d;
    logic pmw_q, pmw_d;
    logic [23:0] pma_q, pma_d;
    logic [15:0] pmd_q, pmd_d;
    logic ior_q, ior_d;
    logic iow_q, iow_d;
    logic [7:0] iod_q, iod_d;
    logic sw_q, sw_d;
    logic sr_q, sr_d;
    logic [7:0] swd_q, swd_d;
    logic brk_q, brk_d;
    logic slp_q, slp_d;
    logic wdr_q, wdr_d;
    logic [7:0] v, r;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        count_d = count_q;
        addr_d = addr_q;
        flags_d = flags_q;
        sp_d = sp_q;
        busy_d = busy_q;
        done_d = 1'b0;
        rw_d = 1'b0;
        res_d = res_q;
        zw_d = 1'b0;
        zv_d = zv_q;
        pmw_d = 1'b0;
        pma_d = pma_q;
        pmd_d = pmd_q;
        ior_d = 1'b0;
        iow_d = 1'b0;
        iod_d = iod_q;
        sw_d = 1'b0;
        sr_d = 1'b0;
        swd_d = swd_q;
        brk_d = 1'b0;
        slp_d = 1'b0;
        wdr_d = 1'b0;
        v = operand_value;
        r = operand_value;
        case (state_q)
            st_idle: begin
                if (op_valid) begin
                    op_d = op_code;
                    addr_d = io_address;
                    case (op_code)
                        op_store_program_memory: begin
                            pmw_d = 1'b1;
                            pma_d = {program_address_extension, z_pointer};
                            pmd_d = {reg_r1, reg_r0};
                            zw_d = 1'b1;
                            zv_d = z_pointer + Z_STEP;
                            done_d = 1'b1;
                        end
                        op_io_in: begin
                            rw_d = 1'b1;
                            res_d = io_read_data;
                            ior_d = 1'b1;
                            done_d = 1'b1;
                        end
                        op_io_out: begin
                            iow_d = 1'b1;
                            iod_d = operand_value;
                            done_d = 1'b1;
                        end
                        op_push: begin
                            sw_d = 1'b1;
                            swd_d = operand_value;
                            sp_d = sp_q - 16'h0001;
                            count_d = 2'(PUSH_CYCLES - 1 + (sram_access ? SRAM_EXTRA_CYCLES : 0));
                            if (count_d == 2'h0 && !mem_wait) begin
                                done_d = 1'b1;
                            end else begin
                                busy_d = 1'b1;
                                state_d = st_wait;
                            end
                        end
                        op_pop: begin
                            sr_d = 1'b1;
                            sp_d = sp_q + 16'h0001;
                            count_d = 2'(POP_CYCLES - 1 + (sram_access ? SRAM_EXTRA_CYCLES : 0));
                            busy_d = 1'b1;
                            state_d = st_wait;
                        end
                        op_set_io_bit, op_clear_io_bit: begin
                            // Read-modify-write of the addressed byte within the take cycle; other bits pass.
                            ior_d = 1'b1;
                            iow_d = 1'b1;
                            iod_d = io_read_data;
                            iod_d[bit_index] = (op_code == op_set_io_bit);
                            done_d = 1'b1;
                        end
                        default: begin
                            done_d = 1'b1;
                            case (op_code)
                                op_logical_shift_left: begin
                                    r = {v[6:0], 1'b0};
                                    flags_d[FLAG_C] = v[7];
                                    flags_d[FLAG_H] = v[3];
                                end
                                op_rotate_left_through_carry: begin
                                    r = {v[6:0], flags_q[FLAG_C]};
                                    flags_d[FLAG_C] = v[7];
                                    flags_d[FLAG_H] = v[3];
                                end
                                op_logical_shift_right: begin
                                    r = {1'b0, v[7:1]};
                                    flags_d[FLAG_C] = v[0];
                                end
                                op_rotate_right_through_carry: begin
                                    r = {flags_q[FLAG_C], v[7:1]};
                                    flags_d[FLAG_C] = v[0];
                                end
                                op_arithmetic_shift_right: begin
                                    r = {v[7], v[7:1]};
                                    flags_d[FLAG_C] = v[0];
                                end
                                op_swap_nibbles: r = {v[3:0], v[7:4]};
                                op_load_bit_from_transfer_flag: r[bit_index] = flags_q[FLAG_T];
                                default: r = v;
                            endcase
                            case (op_code)
                                op_logical_shift_left, op_rotate_left_through_carry, op_logical_shift_right,
                                op_rotate_right_through_carry, op_arithmetic_shift_right: begin
                                    flags_d[FLAG_Z] = (r == 8'h00);
                                    flags_d[FLAG_N] = r[7];
                                    flags_d[FLAG_V] = r[7] ^ flags_d[FLAG_C];
                                    flags_d[FLAG_S] = r[7] ^ flags_d[FLAG_V];
                                    rw_d = 1'b1;
                                    res_d = r;
                                end
                                op_swap_nibbles, op_load_bit_from_transfer_flag: begin
                                    rw_d = 1'b1;
                                    res_d = r;
                                end
                                op_set_indexed_status_flag: flags_d[bit_index] = 1'b1;
                                op_clear_indexed_status_flag: flags_d[bit_index] = 1'b0;
                                op_store_bit_to_transfer_flag: flags_d[FLAG_T] = v[bit_index];
                                op_break: brk_d = 1'b1;
                                op_sleep: slp_d = 1'b1;
                                op_watchdog_restart_instr: wdr_d = 1'b1;
                                default: done_d = 1'b1;
                            endcase
                        end
                    endcase
                end
            end
            st_wait: begin
                // External memory may hold the access beyond the internal figure.
                if (count_q > 2'h1) begin
                    count_d = count_q - 2'h1;
                end else if (!mem_wait) begin
                    if (op_q == op_pop) begin
                        rw_d = 1'b1;
                        res_d = stack_read_data;
                    end
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    count_d = 2'h0;
                    state_d = st_idle;
                end
            end
            default: begin
                state_d = st_idle;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= st_idle;
            op_q <= op_nop;
            count_q <= 2'h0;
            addr_q <= 6'h00;
            flags_q <= FLAGS_RESET;
            sp_q <= SP_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rw_q <= 1'b0;
            res_q <= 8'h00;
            zw_q <= 1'b0;
            zv_q <= 16'h0000;
            pmw_q <= 1'b0;
            pma_q <= 24'h000000;
            pmd_q <= 16'h0000;
            ior_q <= 1'b0;
            iow_q <= 1'b0;
            iod_q <= 8'h00;
            sw_q <= 1'b0;
            sr_q <= 1'b0;
            swd_q <= 8'h00;
            brk_q <= 1'b0;
            slp_q <= 1'b0;
            wdr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            count_q <= count_d;
            addr_q <= addr_d;
            flags_q <= flags_d;
            sp_q <= sp_d;
            busy_q <= busy_d;
            done_q <= done_d;
            rw_q <= rw_d;
            res_q <= res_d;
            zw_q <= zw_d;
            zv_q <= zv_d;
            pmw_q <= pmw_d;
            pma_q <= pma_d;
            pmd_q <= pmd_d;
            ior_q <= ior_d;
            iow_q <= iow_d;
            iod_q <= iod_d;
            sw_q <= sw_d;
            sr_q <= sr_d;
            swd_q <= swd_d;
            brk_q <= brk_d;
            slp_q <= slp_d;
            wdr_q <= wdr_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign result_write = rw_q;
    assign result_value = res_q;
    assign status_flags_register = flags_q;
    assign z_write = zw_q;
    assign z_value = zv_q;
    assign pm_write = pmw_q;
    assign pm_address = pma_q;
    assign pm_data = pmd_q;
    assign io_read = ior_q;
    assign io_write = iow_q;
    assign io_write_address = addr_q;
    assign io_write_data = iod_q;
    assign stack_write = sw_q;
    assign stack_read = sr_q;
    assign stack_pointer = sp_q;
    assign stack_write_data = swd_q;
    assign break_event = brk_q;
    assign sleep_request = slp_q;
    assign watchdog_restart = wdr_q;

endmodule

`default_nettype wire

// ---- rtl/exec_unit_pkg.sv ----
package exec_unit_pkg;

    // ------------------------------------------------------------
    // Operation codes presented on op_code
    // ------------------------------------------------------------
    localparam int OP_WIDTH = 5;
    typedef enum logic [4:0] {
        op_nop = 5'h00,
        op_store_program_memory = 5'h01,
        op_io_in = 5'h02,
        op_io_out = 5'h03,
        op_push = 5'h04,
        op_pop = 5'h05,
        op_logical_shift_left = 5'h06,
        op_logical_shift_right = 5'h07,
        op_rotate_left_through_carry = 5'h08,
        op_rotate_right_through_carry = 5'h09,
        op_arithmetic_shift_right = 5'h0A,
        op_swap_nibbles = 5'h0B,
        op_set_indexed_status_flag = 5'h0C,
        op_clear_indexed_status_flag = 5'h0D,
        op_set_io_bit = 5'h0E,
        op_clear_io_bit = 5'h0F,
        op_store_bit_to_transfer_flag = 5'h10,
        op_load_bit_from_transfer_flag = 5'h11,
        op_break = 5'h12,
        op_sleep = 5'h13,
        op_watchdog_restart_instr = 5'h14
    } op_type;

    // ------------------------------------------------------------
    // Status flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] Z_STEP = 16'h0002;
    localparam logic [15:0] SP_RESET = 16'hFFFF;

    // Cycle counts for internal memory; the SRAM penalty adds one.
    localparam int PUSH_CYCLES = 1;
    localparam int POP_CYCLES = 2;
    localparam int SRAM_EXTRA_CYCLES = 1;

endpackage

// ---- tb/bit_flag_transfer_exec_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module bit_flag_transfer_exec_unit_bench;
    import exec_unit_pkg::*;
    // --------
    // Bench
    // --------
    logic clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, sram_access = 1'b0, slow = 1'b0;
    op_type op_code = op_nop;
    logic [7:0] operand_value = 8'h00, reg_r0 = 8'h00, reg_r1 = 8'h00, ext = 8'h00, exp_flags = 8'h00;
    logic [2:0] bit_index = 3'h0;
    logic [5:0] io_address = 6'h00;
    logic [15:0] z_pointer = 16'h0000;
    wire logic mem_wait, busy, done, result_write, z_write, pm_write, io_read, io_write, stack_write, stack_read;
    wire logic break_event, sleep_request, watchdog_restart;
    wire logic [7:0] io_read_data, stack_read_data, result_value, flags, io_write_data, stack_write_data;
    wire logic [15:0] z_value, pm_data, stack_pointer;
    wire logic [23:0] pm_address;
    wire logic [5:0] io_write_address;
    int bad_count = 0, samples_checked = 0;
    logic [7:0] pushed [$];

    exec_mem_model u_exec_mem_model (.clk(clk), .slow(slow), .io_address(io_address), .io_write(io_write),
        .io_write_address(io_write_address), .io_write_data(io_write_data), .stack_write(stack_write),
        .stack_read(stack_read), .stack_write_data(stack_write_data), .mem_wait(mem_wait),
        .io_read_data(io_read_data), .stack_read_data(stack_read_data));
    bit_flag_transfer_exec_unit u_bit_flag_transfer_exec_unit (.clk(clk), .reset_n(reset_n),
        .op_valid(op_valid), .op_code(op_code), .operand_value(operand_value), .bit_index(bit_index),
        .io_address(io_address), .reg_r0(reg_r0), .reg_r1(reg_r1), .z_pointer(z_pointer),
        .program_address_extension(ext), .sram_access(sram_access), .mem_wait(mem_wait),
        .io_read_data(io_read_data), .stack_read_data(stack_read_data), .busy(busy), .done(done),
        .result_write(result_write), .result_value(result_value), .status_flags_register(flags),
        .z_write(z_write), .z_value(z_value), .pm_write(pm_write), .pm_address(pm_address), .pm_data(pm_data),
        .io_read(io_read), .io_write(io_write), .io_write_address(io_write_address),
        .io_write_data(io_write_data), .stack_write(stack_write), .stack_read(stack_read),
        .stack_pointer(stack_pointer), .stack_write_data(stack_write_data), .break_event(break_event),
        .sleep_request(sleep_request), .watchdog_restart(watchdog_restart));

    always #4 clk = ~clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic run(input op_type op, input logic [7:0] v, input logic [2:0] b);
        int n;
        int cyc;
        logic [8:0] sh;
        logic [7:0] want;
        logic [7:0] io_exp;
        logic wr;
        want = u_exec_mem_model.io_mem[io_address];
        io_exp = want;
        io_exp[b] = (op == op_set_io_bit);
        wr = op inside {[op_logical_shift_left:op_swap_nibbles], op_io_in, op_pop, op_load_bit_from_transfer_flag};
        case (op)
            op_logical_shift_left: sh = {v, 1'b0};
            op_logical_shift_right: sh = {v[0], 1'b0, v[7:1]};
            op_rotate_left_through_carry: sh = {v, exp_flags[FLAG_C]};
            op_rotate_right_through_carry: sh = {v[0], exp_flags[FLAG_C], v[7:1]};
            default: sh = {v[0], v[7], v[7:1]};
        endcase
        if (op inside {[op_logical_shift_left:op_arithmetic_shift_right]}) begin
            want = sh[7:0];
            if (op == op_logical_shift_left || op == op_rotate_left_through_carry) exp_flags[FLAG_H] = v[3];
            // Sign works out to N xor (N xor C), which is the carry out.
            exp_flags[4:0] = {sh[8], sh[7] ^ sh[8], sh[7], sh[7:0] == 8'h00, sh[8]};
        end
        if (op == op_swap_nibbles) want = {v[3:0], v[7:4]};
        if (op == op_pop) want = pushed.pop_back();
        if (op == op_push) pushed.push_back(v);
        if (op == op_load_bit_from_transfer_flag) want = v ^ (8'(v[b] ^ exp_flags[FLAG_T]) << b);
        if (op == op_store_bit_to_transfer_flag) exp_flags[FLAG_T] = v[b];
        if (op == op_set_indexed_status_flag) exp_flags[b] = 1'b1;
        if (op == op_clear_indexed_status_flag) exp_flags[b] = 1'b0;
        cyc = (op == op_push) ? 1 + sram_access : (op == op_pop) ? 2 + sram_access : 1;
        if (slow && (op == op_push || op == op_pop)) cyc = 0;
        op_code = op;
        operand_value = v;
        bit_index = b;
        op_valid = 1'b1;
        @(posedge clk);
        @(negedge clk);
        // A flag op offered while busy must be ignored; it would show in the flags.
        if (!busy) op_valid = 1'b0;
        else op_code = exp_flags[b] ? op_clear_indexed_status_flag : op_set_indexed_status_flag;
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        op_valid = 1'b0;
        if (cyc > 0) check(64'(n), 64'(cyc));
        check(done, 1'b1);
        check(result_write, wr);
        if (wr) check(result_value, want);
        check(flags, exp_flags);
        check(io_read, op inside {op_io_in, op_set_io_bit, op_clear_io_bit});
        check(stack_pointer, SP_RESET - 16'(pushed.size()));
        check({break_event, sleep_request, watchdog_restart},
            {op == op_break, op == op_sleep, op == op_watchdog_restart_instr});
        if (op inside {op_set_io_bit, op_clear_io_bit, op_io_out})
            check({io_write, io_write_address, io_write_data}, {1'b1, io_address, op == op_io_out ? v : io_exp});
        if (op == op_store_program_memory) check({pm_write, z_write, z_value, pm_data, pm_address},
            {2'b11, z_pointer + 16'h0002, reg_r1, reg_r0, ext, z_pointer});
    endtask

    initial begin
        op_type op;
        void'($urandom(39242));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 16; i++) run(i < 8 ? op_set_indexed_status_flag : op_clear_indexed_status_flag, 8'h00, 3'(i));
        z_pointer = 16'hFFFE;
        run(op_set_indexed_status_flag, 8'h00, 3'h0);
        run(op_rotate_left_through_carry, 8'h80, 3'h0);
        run(op_store_program_memory, 8'h00, 3'h0);
        sram_access = 1'b1;
        run(op_push, 8'h3C, 3'h0);
        slow = 1'b1;
        run(op_pop, 8'h00, 3'h5);
        slow = 1'b0;
        run(op_set_io_bit, 8'h00, 3'h7);
        for (int i = 0; i < 300; i++) begin
            op = op_type'($urandom_range(0, 20));
            if (op == op_pop && pushed.size() == 0) op = op_push;
            {reg_r0, reg_r1, ext, z_pointer} = 40'({$urandom, $urandom});
            {io_address, sram_access} = 7'($urandom);
            slow = ($urandom_range(0, 7) == 0);
            run(op, 8'($urandom), 3'($urandom));
        end
        tally_and_finish();
    end

    // Some 320 operations of at most a few dozen cycles each fit well inside this span.
    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
endmodule

bind bit_flag_transfer_exec_unit exec_unit_asserts u_exec_unit_asserts (.clk(clk), .reset_n(reset_n),
    .op_valid(op_valid), .op_code(op_code), .operand_value(operand_value), .bit_index(bit_index),
    .sram_access(sram_access), .mem_wait(mem_wait), .io_read_data(io_read_data), .busy(busy), .done(done),
    .result_write(result_write), .result_value(result_value), .status_flags_register(status_flags_register),
    .z_write(z_write), .z_value(z_value), .pm_write(pm_write), .pm_address(pm_address), .io_read(io_read),
    .io_write(io_write), .watchdog_restart(watchdog_restart));

`default_nettype wire

// ---- tb/exec_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module exec_mem_model (
    input wire logic clk, // Clock.
    input wire logic slow, // Stretch stack accesses.
    input wire logic [5:0] io_address, // Location read.
    input wire logic io_write, // I/O write strobe.
    input wire logic [5:0] io_write_address, // Location written.
    input wire logic [7:0] io_write_data, // Data written.
    input wire logic stack_write, // Push strobe.
    input wire logic stack_read, // Pop strobe.
    input wire logic [7:0] stack_write_data, // Data pushed.
    output logic mem_wait, // Access stretch.
    output logic [7:0] io_read_data, // I/O data.
    output logic [7:0] stack_read_data // Popped data.
);
    // --------
    // Memories
    // --------
    logic [7:0] io_mem [64];
    logic [7:0] stk [256];
    logic [7:0] depth = 8'h00;
    logic [7:0] pop_q = 8'h5A;
    logic [1:0] hold_q = 2'h0;

    initial for (int i = 0; i < 64; i++) io_mem[i] = 8'(i * 29 + 5);
    // A slow access keeps the core waiting for two cycles after its strobe, then lets it finish.
    assign mem_wait = slow && (stack_read || stack_write || hold_q != 2'h0);
    assign io_read_data = io_mem[io_address];
    // The popped byte stays up after the strobe, since the core may look late.
    assign stack_read_data = stack_read ? stk[depth - 8'h01] : pop_q;
    always @(posedge clk) begin
        hold_q <= (stack_read || stack_write) ? 2'h2 : hold_q - 2'(hold_q != 2'h0);
        if (io_write) io_mem[io_write_address] <= io_write_data;
        if (stack_write) begin
            stk[depth] <= stack_write_data;
            depth <= depth + 8'h01;
        end
        if (stack_read) begin
            pop_q <= stk[depth - 8'h01];
            depth <= depth - 8'h01;
        end
    end
endmodule

`default_nettype wire

// ---- tb/exec_unit_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module exec_unit_asserts
    import exec_unit_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic op_valid, // Offer.
    input wire exec_unit_pkg::op_type op_code, // Operation.
    input wire logic [7:0] operand_value, // Operand.
    input wire logic [2:0] bit_index, // Bit select.
    input wire logic sram_access, // SRAM penalty.
    input wire logic mem_wait, // Stretch.
    input wire logic [7:0] io_read_data, // I/O data.
    input wire logic busy, // Busy.
    input wire logic done, // Retire.
    input wire logic result_write, // Result strobe.
    input wire logic [7:0] result_value, // Result.
    input wire logic [7:0] status_flags_register, // Flags.
    input wire logic z_write, // Z strobe.
    input wire logic [15:0] z_value, // New Z.
    input wire logic pm_write, // Program write.
    input wire logic [23:0] pm_address, // Program address.
    input wire logic io_read, // I/O read.
    input wire logic io_write, // I/O write.
    input wire logic watchdog_restart // Watchdog.
);
    // --------
    // Checks
    // --------
    wire logic take = op_valid && !busy;
    wire logic sel_bit = operand_value[bit_index];
    wire logic [8:0] rol_exp = {operand_value, status_flags_register[FLAG_C]};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Flags may only move on the edge that retires an operation.
    property p_flags_hold;
        !done |-> $stable(status_flags_register);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved outside a retire");
    property p_pm_pair;
        pm_write |-> z_write && z_value == pm_address[15:0] + 16'h0002;
    endproperty
    a_pm_pair: assert property (p_pm_pair) else $error("pointer not advanced by two");
    property p_in_copy;
        take && op_code == op_io_in |=> done && result_write && result_value == $past(io_read_data);
    endproperty
    a_in_copy: assert property (p_in_copy) else $error("input copy wrong");
    property p_push_one;
        take && op_code == op_push && !sram_access && !mem_wait |=> done;
    endproperty
    a_push_one: assert property (p_push_one) else $error("push not one cycle");
    property p_pop_two;
        take && op_code == op_pop && !sram_access && !mem_wait ##1 !mem_wait |-> busy && !done ##1 done && result_write;
    endproperty
    a_pop_two: assert property (p_pop_two) else $error("pop not two cycles");
    property p_rol;
        take && op_code == op_rotate_left_through_carry |=>
            {status_flags_register[FLAG_C], result_value} == $past(rol_exp);
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");
    property p_io_set;
        take && op_code == op_set_io_bit |=> io_read && io_write && done;
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set sequence wrong");
    property p_tflag;
        take && op_code == op_store_bit_to_transfer_flag |=> status_flags_register[FLAG_T] == $past(sel_bit);
    endproperty
    a_tflag: assert property (p_tflag) else $error("transfer flag wrong");
    property p_sram;
        take && op_code == op_push && sram_access && !mem_wait ##1 !mem_wait |-> !done ##1 done;
    endproperty
    a_sram: assert property (p_sram) else $error("sram cycle missing");
    c_pop: cover property (take && op_code == op_pop);
    c_io: cover property (io_write);
    c_wdr: cover property (watchdog_restart);
endmodule

`default_nettype wire
